// [hw/mcd_defs.vh]
// Constants for the monitor channel-disable and one-shot control block.
// Assumes a same-clock register port fed by the serial bus front end.
`ifndef MCD_DEFS_VH
`define MCD_DEFS_VH
`define MCD_OFS_DISABLE 8'h08
`define MCD_OFS_ONESHOT 8'h09
`define MCD_DISABLE_RESET 8'h00
`define MCD_ONESHOT_READ 8'h00
`define MCD_ONESHOT_BIT 0
`define MCD_MODE0 2'h0
`define MCD_MODE1 2'h1
`define MCD_MODE2 2'h2
`define MCD_MODE3 2'h3
`define MCD_WMASK_FULL 8'hff
`define MCD_WMASK_MODE2 8'h8f
`define MCD_WMASK_MODE3 8'hbf
`define MCD_SLOTS 4'h8
`define MCD_ST_SHUT 2'h0
`define MCD_ST_DEEP 2'h1
`define MCD_ST_RUN 2'h2
`define MCD_ST_ONESHOT 2'h3
`endif

// [hw/mcd_step.v]
// Channel slot stepper: walks slots 0..7 once, requesting only enabled ones.
// Assumes the sequencer answers each request with a one-cycle ack on the same clock.
`timescale 1ns/1ns
`include "mcd_defs.vh"
module mcd_step (
  input wire clk_sys,
  input wire rst_n,
  input wire start,
  input wire [7:0] slot_en,
  input wire ack,
  output reg req,
  output reg [2:0] slot,
  output reg done
);
  reg busy;
  reg [3:0] idx;

  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      busy <= 1'b0;
      req <= 1'b0;
      slot <= 3'h0;
      done <= 1'b0;
      idx <= 4'h0;
    end
    else
    begin
      done <= 1'b0;
      if (start && !busy)
      begin
        busy <= 1'b1;
        idx <= 4'h0;
      end
      else if (busy && req)
      begin
        if (ack)
        begin
          req <= 1'b0;
          idx <= idx + 4'h1;
        end
      end
      else if (busy)
      begin
        if (idx == `MCD_SLOTS)
        begin
          busy <= 1'b0;
          done <= 1'b1;
        end
        else if (slot_en[idx[2:0]])
        begin
          req <= 1'b1;
          slot <= idx[2:0];
        end
        else
          idx <= idx + 4'h1;
      end
    end
  end
endmodule

// [hw/mcd_top.v]
// Channel disable mask, mode-dependent layout and one-shot conversion control.
// Assumes register port, run bit, deep flag, mode select and sequencer acks share clk_sys.
`timescale 1ns/1ns
`include "mcd_defs.vh"
module mcd_top (
  input wire clk_sys,
  input wire rst_n,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  output reg reg_rd_valid,
  input wire run_enable,
  input wire deep_shutdown,
  input wire [1:0] mode_sel,
  input wire conv_ack,
  output reg conv_req,
  output reg [2:0] conv_slot,
  output reg conv_compare,
  output reg [7:0] slot_disable,
  output reg readings_clear,
  output reg alarms_clear,
  output reg busy,
  output reg [1:0] monitor_state
);
  localparam ST_IDLE = 2'h0;
  localparam ST_CONV = 2'h1;
  localparam ST_CMP = 2'h2;

  reg [7:0] disable_mask;
  reg [1:0] fsm;
  reg [1:0] next_fsm;
  reg oneshot_run;
  reg saved_deep;
  reg step_start;
  reg [7:0] wmask;
  reg [7:0] slot_off;
  wire in_shutdown;
  wire wr_disable;
  wire wr_oneshot;
  wire step_req;
  wire [2:0] step_slot;
  wire step_done;

  assign in_shutdown = !run_enable;
  assign wr_disable = reg_wr && (reg_addr == `MCD_OFS_DISABLE);
  assign wr_oneshot = reg_wr && (reg_addr == `MCD_OFS_ONESHOT) &&
                      reg_wdata[`MCD_ONESHOT_BIT];

  // Slot i always pairs with disable bit i; reserved slots never convert
  always @*
  begin
    case (mode_sel)
      `MCD_MODE0: wmask = `MCD_WMASK_FULL;
      `MCD_MODE1: wmask = `MCD_WMASK_FULL;
      `MCD_MODE2: wmask = `MCD_WMASK_MODE2;
      `MCD_MODE3: wmask = `MCD_WMASK_MODE3;
      default: wmask = `MCD_WMASK_FULL;
    endcase
    slot_off = (disable_mask & wmask) | ~wmask;
  end

  // Host keeps writes to shutdown; the mask is accepted regardless to stay simple
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      disable_mask <= `MCD_DISABLE_RESET;
    else if (wr_disable)
      disable_mask <= reg_wdata & wmask;
  end

  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      readings_clear <= 1'b0;
      alarms_clear <= 1'b0;
      slot_disable <= 8'h00;
    end
    else
    begin
      readings_clear <= wr_disable;
      alarms_clear <= wr_disable;
      slot_disable <= slot_off;
    end
  end

  // Reads: the one-shot register never shows a one, reserved bits read zero
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reg_rdata <= 8'h00;
      reg_rd_valid <= 1'b0;
    end
    else
    begin
      reg_rd_valid <= reg_rd && ((reg_addr == `MCD_OFS_DISABLE) ||
                                 (reg_addr == `MCD_OFS_ONESHOT));
      if (reg_rd && (reg_addr == `MCD_OFS_DISABLE))
        reg_rdata <= disable_mask & wmask;
      else
        reg_rdata <= `MCD_ONESHOT_READ;
    end
  end

  always @*
  begin
    next_fsm = fsm;
    case (fsm)
      ST_IDLE:
      begin
        if (run_enable || (wr_oneshot && in_shutdown))
          next_fsm = ST_CONV;
      end
      ST_CONV:
      begin
        if (step_done)
          next_fsm = ST_CMP;
      end
      ST_CMP:
      begin
        if (step_done)
          next_fsm = ST_IDLE;
      end
      default: next_fsm = ST_IDLE;
    endcase
  end

  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fsm <= ST_IDLE;
      oneshot_run <= 1'b0;
      saved_deep <= 1'b0;
      step_start <= 1'b0;
      conv_compare <= 1'b0;
      busy <= 1'b0;
      monitor_state <= `MCD_ST_SHUT;
    end
    else
    begin
      fsm <= next_fsm;
      step_start <= (fsm != next_fsm) && (next_fsm != ST_IDLE);
      busy <= (next_fsm != ST_IDLE);
      if (fsm == ST_IDLE && next_fsm == ST_CONV)
      begin
        oneshot_run <= !run_enable;
        saved_deep <= deep_shutdown;
        conv_compare <= 1'b0;
      end
      else if (fsm == ST_CONV && next_fsm == ST_CMP)
        conv_compare <= 1'b1;
      else if (fsm == ST_CMP && next_fsm == ST_IDLE)
        oneshot_run <= 1'b0;
      if (next_fsm != ST_IDLE && (oneshot_run || (fsm == ST_IDLE && !run_enable)))
        monitor_state <= `MCD_ST_ONESHOT;
      else if (fsm == ST_CMP && next_fsm == ST_IDLE && oneshot_run)
        monitor_state <= saved_deep ? `MCD_ST_DEEP : `MCD_ST_SHUT;
      else if (run_enable)
        monitor_state <= `MCD_ST_RUN;
      else if (next_fsm == ST_IDLE)
        monitor_state <= deep_shutdown ? `MCD_ST_DEEP : `MCD_ST_SHUT;
    end
  end

  mcd_step u_step (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .start(step_start),
    .slot_en(~slot_off),
    .ack(conv_ack),
    .req(step_req),
    .slot(step_slot),
    .done(step_done)
  );

  // Re-registered so the sequencer sees flop outputs only
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      conv_req <= 1'b0;
      conv_slot <= 3'h0;
    end
    else
    begin
      conv_req <= step_req && !conv_ack;
      conv_slot <= step_slot;
    end
  end
endmodule

// [tb/mcd_props.sv]
// Port checker for the channel-disable and one-shot block.
// Assumes one clock and the active-low reset of the top.
`timescale 1ns/1ns
module mcd_props (
  input wire clk_sys,
  input wire rst_n,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  input wire reg_rd_valid,
  input wire run_enable,
  input wire [1:0] mode_sel,
  input wire conv_ack,
  input wire conv_req,
  input wire [2:0] conv_slot,
  input wire conv_compare,
  input wire [7:0] slot_disable,
  input wire readings_clear,
  input wire alarms_clear,
  input wire busy,
  input wire [1:0] monitor_state
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence s_mask_wr;
    reg_wr && reg_addr == 8'h08;
  endsequence
  sequence s_shot_wr;
    reg_wr && reg_addr == 8'h09 && reg_wdata[0] && !run_enable && !busy;
  endsequence
  a_wr_clears: assert property (s_mask_wr |=> readings_clear && alarms_clear)
    else $error("No clear after mask write");
  a_clear_cause: assert property (readings_clear |-> $past(reg_wr) && $past(reg_addr) == 8'h08)
    else $error("Stray clear");
  a_read_zero: assert property (reg_rd && reg_addr == 8'h09 |=> reg_rd_valid && reg_rdata == 8'h00)
    else $error("One-shot read not zero");
  a_shot_start: assert property (s_shot_wr |=> busy && monitor_state == 2'h3)
    else $error("One-shot did not start");
  a_shot_return: assert property ($fell(busy) && !run_enable |-> ##[0:1] monitor_state < 2'h2)
    else $error("No return to shutdown");
  a_mode2_reserved: assert property (mode_sel == 2'h2 && $past(mode_sel) == 2'h2
    && $past(rst_n) |-> slot_disable[6:4] == 3'h7)
    else $error("Mode 2 reserved slots live");
  a_mode3_reserved: assert property (mode_sel == 2'h3 && $past(mode_sel) == 2'h3
    && $past(rst_n) |-> slot_disable[6])
    else $error("Mode 3 reserved slot live");
  a_conv_first: assert property ($rose(busy) |-> !conv_compare)
    else $error("Pass began with compare");
  a_req_holds: assert property (conv_req && !conv_ack |=> conv_req && $stable(conv_slot))
    else $error("Request dropped early");
  a_skip_disabled: assert property (conv_req |-> !slot_disable[conv_slot])
    else $error("Disabled slot requested");
endmodule
bind mcd_top mcd_props u_mcd_props (.clk_sys, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .reg_rd_valid, .run_enable, .mode_sel, .conv_ack, .conv_req, .conv_slot,
  .conv_compare, .slot_disable, .readings_clear, .alarms_clear, .busy, .monitor_state);

// [tb/mcd_seq_model.sv]
// Sequencer stand-in: acks each request, promptly or after a stall.
// Assumes requests hold until acked, on clk_sys.
`timescale 1ns/1ns
module mcd_seq_model (
  input wire clk_sys,
  input wire rst_n,
  input wire conv_req,
  input wire slow,
  output reg conv_ack,
  output reg [7:0] acks
);
  reg [1:0] stall;
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      conv_ack <= 1'b0;
      stall <= 2'h0;
      acks <= 8'h00;
    end
    else
    begin
      // Request lingers a cycle after an ack, so never ack twice
      conv_ack <= conv_req && !conv_ack && (!slow || stall == 2'h3);
      stall <= (conv_req && !conv_ack) ? stall + 2'h1 : 2'h0;
      acks <= acks + {7'h00, conv_ack};
    end
  end
endmodule

// [tb/mcd_top_tb.sv]
// Bench: register strobes, mode layouts and one-shot passes.
// Assumes the sequencer stand-in answers every request.
`timescale 1ns/1ns
module mcd_top_tb;
  reg clk_sys = 1'b0;
  reg rst_n = 1'b0;
  reg [7:0] reg_addr = 8'h00;
  reg [7:0] reg_wdata = 8'h00;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  reg run_enable = 1'b0;
  reg deep_shutdown = 1'b0;
  reg [1:0] mode_sel = 2'h0;
  reg slow = 1'b0;
  wire conv_ack, conv_req, conv_compare, readings_clear, alarms_clear, busy, reg_rd_valid;
  wire [7:0] reg_rdata, slot_disable, acks;
  wire [2:0] conv_slot;
  wire [1:0] monitor_state;
  integer miscompares = 0;
  integer checks = 0;
  integer i;
  reg [7:0] base;
  initial forever #4 clk_sys = ~clk_sys;
  mcd_top u_mcd_top (.clk_sys, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .reg_rd_valid, .run_enable, .deep_shutdown, .mode_sel, .conv_ack, .conv_req, .conv_slot,
    .conv_compare, .slot_disable, .readings_clear, .alarms_clear, .busy, .monitor_state);
  mcd_seq_model u_mcd_seq_model (.clk_sys, .rst_n, .conv_req, .slow, .conv_ack, .acks);
  task check(input [7:0] seen, input [7:0] exp);
  begin
    checks = checks + 1;
    if (seen !== exp)
    begin
      miscompares = miscompares + 1;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  end
  endtask
  task wr(input [7:0] a, input [7:0] d);
  begin
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
    @(negedge clk_sys);
  end
  endtask
  task rd(input [7:0] a, input [7:0] exp, input v);
  begin
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    check({7'h00, reg_rd_valid}, {7'h00, v});
    if (v)
      check(reg_rdata, exp);
    // Idle cycle so back-to-back reads never re-raise the strobe in one step
    @(negedge clk_sys);
  end
  endtask
  task shot(input [7:0] n, input [7:0] st);
  begin
    base = acks;
    wr(8'h09, 8'h01);
    for (i = 0; i < 400 && busy === 1'b1; i = i + 1)
      @(negedge clk_sys);
    @(negedge clk_sys);
    check(acks - base, n);
    check({7'h00, conv_compare}, 8'h01);
    check({6'h00, monitor_state}, st);
  end
  endtask
  task print_verdict;
  begin
    $display("Checks %0d, miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  end
  endtask
  initial
  begin
    repeat (4) @(negedge clk_sys);
    rst_n = 1'b1;
    rd(8'h08, 8'h00, 1'b1);
    rd(8'h09, 8'h00, 1'b1);
    rd(8'h0a, 8'h00, 1'b0);
    for (i = 0; i < 4; i = i + 1)
    begin
      mode_sel = i[1:0];
      base = (i == 2) ? 8'h8f : (i == 3) ? 8'hbf : 8'hff;
      wr(8'h08, 8'hff);
      rd(8'h08, base, 1'b1);
      wr(8'h08, 8'h00);
      check(slot_disable, ~base);
    end
    mode_sel = 2'h1;
    wr(8'h08, 8'h05);
    check(slot_disable, 8'h05);
    shot(8'h0c, 8'h00);
    rd(8'h09, 8'h00, 1'b1);
    mode_sel = 2'h2;
    deep_shutdown = 1'b1;
    slow = 1'b1;
    wr(8'h08, 8'h81);
    shot(8'h06, 8'h01);
    deep_shutdown = 1'b0;
    run_enable = 1'b1;
    repeat (3) @(negedge clk_sys);
    check({6'h00, monitor_state}, 8'h02);
    wr(8'h09, 8'h01);
    check({6'h00, monitor_state}, 8'h02);
    print_verdict;
  end
  initial
  begin
    #40000;
    miscompares = miscompares + 1;
    print_verdict;
  end
endmodule
